//--- lpw_asserts.sv
// checker for the log page write link
`timescale 1ns/100ps
`default_nettype none
module lpw_asserts
  import lpw_pkg::*;
(
  input wire logic       clock_in,
  input wire logic       srst_in,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [7:0] count_cur,
  input wire logic [7:0] count_prev,
  input wire logic [7:0] log_addr,
  input wire logic       data_valid,
  input wire logic       drq,
  input wire logic       intrq,
  input wire logic       done,
  input wire logic [7:0] error_reg,
  input wire logic [7:0] status_reg
);
  logic [7:0] wcnt_q;
  default clocking @(posedge clock_in); endclocking
  default disable iff (srst_in);
  always_ff @(posedge clock_in) begin
    if (srst_in || done) begin
      wcnt_q <= 8'h00;
    end else if (data_valid && drq) begin
      wcnt_q <= wcnt_q + 8'h01;
    end
  end
  sequence s_launch;
    cmd_valid && !drq;
  endsequence
  sequence s_last_word;
    data_valid && drq && wcnt_q == 8'hFF && cmd_opcode == OPC_PIO_WRITE;
  endsequence
  a_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_intrq_pulse: assert property (intrq |=> !intrq)
    else $error("intrq longer than one cycle");
  a_bad_opcode: assert property (s_launch ##0 (cmd_opcode != OPC_PIO_WRITE &&
    cmd_opcode != OPC_DMA_WRITE) |-> ##[1:3] done) else $error("bad opcode not aborted");
  a_zero_count: assert property (s_launch ##0 {count_prev, count_cur} == 16'h0000
    |-> ##[1:3] done) else $error("zero count not aborted");
  a_log_range: assert property (s_launch ##0 log_addr >= LOG_COUNT |->
    !drq [*2] ##[0:1] done) else $error("bad log not aborted");
  a_drq_to_done: assert property ($fell(drq) |-> ##[0:4] done)
    else $error("no completion after data");
  a_block_intrq: assert property (s_last_word |-> ##[1:3] intrq)
    else $error("no interrupt after block");
  a_done_status: assert property (done |=> status_reg[ST_RDY] && status_reg[ST_SEEK_DONE] &&
    !status_reg[ST_BSY] && !status_reg[ST_FAULT] && !status_reg[ST_CORRECTED])
    else $error("completion status wrong");
  a_err_summary: assert property (done |=> status_reg[ST_ERR] == (error_reg != 8'h00))
    else $error("error summary wrong");
endmodule : lpw_asserts
`default_nettype wire

//--- lpw_dev.sv
// drive end: checks log write commands and stores sector data
`timescale 1ns/100ps
`default_nettype none
//
// Function
// - opcode 3Fh selects programmed log write
// - opcode 57h selects DMA log write
// - DMA variant shares all checks, storage
// - accept count sectors of 512 bytes
// - interrupt once per programmed data block
// - host splits count low, high bytes
// - abort when count exceeds directory pages
// - store starting at host start page
// - host puts log address in sector number
// - abort writes to read-only logs
// - host splits start page low, high
// - abort when log feature not enabled
// - abort on invalid count, log, page
module lpw_dev
  import lpw_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        srst_in,
  input  wire logic        ce_in,
  lpw_if.dev               lnk,
  input  wire logic [31:0] log_pages_in,
  input  wire logic [3:0]  log_writable_in,
  input  wire logic [3:0]  log_enabled_in,
  output logic             wr_valid_out,
  output logic [7:0]       wr_log_out,
  output logic [15:0]      wr_page_out,
  output logic [7:0]       wr_word_out,
  output logic [15:0]      wr_data_out
);
  typedef enum logic [1:0] {
    DS_IDLE = 2'b00,
    DS_XFER = 2'b01,
    DS_DONE = 2'b10
  } lpw_dstate_t;

  lpw_dstate_t  state_q;
  logic         dma_q;
  logic [15:0]  left_q;
  logic [15:0]  page_q;
  logic [7:0]   word_q;
  logic [7:0]   log_q;
  logic         crc_q;
  logic         drq_q;
  logic         intrq_q;
  logic         done_q;
  logic [7:0]   err_q;
  logic [7:0]   stat_q;
  logic [15:0]  count_w;
  logic [15:0]  start_w;
  logic         known_w;
  logic         abort_w;
  logic         last_word_w;

  function automatic logic [7:0] dir_pages(input logic [31:0] tbl, input logic [7:0] idx);
    dir_pages = tbl[idx[1:0]*8 +: 8];
  endfunction : dir_pages

  assign count_w = {lnk.count_prev, lnk.count_cur};
  assign start_w = {lnk.page_prev, lnk.page_cur};
  assign known_w = (lnk.cmd_opcode == OPC_PIO_WRITE) || (lnk.cmd_opcode == OPC_DMA_WRITE);
  always_comb begin
    abort_w = 1'b0;
    if (lnk.log_addr >= LOG_COUNT || count_w == 16'h0000)
      abort_w = 1'b1;
    else if (!log_enabled_in[lnk.log_addr[1:0]])
      abort_w = 1'b1;
    else if (!log_writable_in[lnk.log_addr[1:0]])
      abort_w = 1'b1;
    else if (count_w > {8'h00, dir_pages(log_pages_in, lnk.log_addr)})
      abort_w = 1'b1;
    else if ({1'b0, start_w} + {1'b0, count_w} >
             {9'h000, dir_pages(log_pages_in, lnk.log_addr)})
      abort_w = 1'b1;
  end
  assign last_word_w = ({2'b00, word_q} == WORDS_PER_SEC - 10'h001);

  // command sequencing
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state_q <= DS_IDLE;
      dma_q   <= 1'b0;
      left_q  <= 16'h0000;
      page_q  <= 16'h0000;
      word_q  <= 8'h00;
      log_q   <= 8'h00;
      crc_q   <= 1'b0;
    end else if (ce_in) begin
      unique case (state_q)
        DS_IDLE: begin
          crc_q <= 1'b0;
          if (lnk.cmd_valid) begin
            if (known_w && !abort_w) begin
              state_q <= DS_XFER;
              dma_q   <= (lnk.cmd_opcode == OPC_DMA_WRITE);
              left_q  <= count_w;
              page_q  <= start_w;
              log_q   <= lnk.log_addr;
              word_q  <= 8'h00;
            end else begin
              state_q <= DS_DONE;
            end
          end
        end
        DS_XFER: begin
          if (lnk.data_valid) begin
            if (lnk.data_crc_err && dma_q)
              crc_q <= 1'b1;
            word_q <= word_q + 8'h01;
            if (last_word_w) begin
              word_q <= 8'h00;
              page_q <= page_q + 16'h0001;
              left_q <= left_q - 16'h0001;
              if (left_q == 16'h0001)
                state_q <= DS_DONE;
            end
          end
        end
        DS_DONE: state_q <= DS_IDLE;
        default: state_q <= DS_IDLE;
      endcase
    end
  end

  // storage write port
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      wr_valid_out <= 1'b0;
      wr_log_out   <= 8'h00;
      wr_page_out  <= 16'h0000;
      wr_word_out  <= 8'h00;
      wr_data_out  <= 16'h0000;
    end else if (ce_in) begin
      wr_valid_out <= (state_q == DS_XFER) && lnk.data_valid;
      wr_log_out   <= log_q;
      wr_page_out  <= page_q;
      wr_word_out  <= word_q;
      wr_data_out  <= lnk.data_word;
    end
  end

  // link handshake outputs
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      drq_q   <= 1'b0;
      intrq_q <= 1'b0;
      done_q  <= 1'b0;
    end else if (ce_in) begin
      drq_q   <= (state_q == DS_XFER) && !(lnk.data_valid && last_word_w && left_q == 16'h0001);
      done_q  <= (state_q == DS_DONE);
      intrq_q <= (state_q == DS_XFER && lnk.data_valid && last_word_w && !dma_q)
                 || (state_q == DS_DONE && dma_q);
    end
  end

  // result registers
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      err_q  <= 8'h00;
      stat_q <= 8'h00;
    end else if (ce_in) begin
      if (state_q == DS_IDLE && lnk.cmd_valid) begin
        err_q <= 8'h00;
        stat_q[ST_BSY] <= 1'b1;
        if (!known_w || abort_w)
          err_q[ERR_ABORTED] <= 1'b1;
      end else if (state_q == DS_DONE) begin
        if (crc_q)
          err_q[ERR_CRC] <= 1'b1;
        stat_q[ST_BSY] <= 1'b0;
        stat_q[ST_FAULT]     <= 1'b0;
        stat_q[ST_CORRECTED] <= 1'b0;
        stat_q[ST_DRQ]       <= 1'b0;
        stat_q[ST_RDY]       <= 1'b1;
        stat_q[ST_SEEK_DONE] <= 1'b1;
        stat_q[ST_ERR] <= (err_q != 8'h00) || crc_q;
      end else begin
        stat_q[ST_DRQ] <= drq_q;
      end
    end
  end

  assign lnk.drq        = drq_q;
  assign lnk.intrq      = intrq_q;
  assign lnk.done       = done_q;
  assign lnk.error_reg  = err_q;
  assign lnk.status_reg = stat_q;
endmodule : lpw_dev
`default_nettype wire

//--- lpw_host.sv
// host adapter end: wishbone registers driving the command block
`timescale 1ns/100ps
`default_nettype none
module lpw_host
  import lpw_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        srst_in,
  input  wire logic        ce_in,
  lpw_if.host              lnk,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [4:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  output logic             irq_out
);
  logic [7:0]  opc_q;
  logic [15:0] count_q;
  logic [7:0]  log_q;
  logic [15:0] page_q;
  logic        go_q;
  logic        dvalid_q;
  logic [15:0] dword_q;
  logic [2:0]  ist_q;
  logic [2:0]  imask_q;
  logic        wr_w;
  logic [2:0]  ev_w;
  logic [2:0]  idx_w;

  assign idx_w = wb_adr_in[4:2];
  // writes land on the edge where the master sees ack
  assign wr_w  = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out && wb_sel_in[0];
  assign ev_w  = {lnk.drq & ~dvalid_q, lnk.intrq, lnk.done};

  // register writes and command launch
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      opc_q    <= 8'h00;
      count_q  <= 16'h0000;
      log_q    <= 8'h00;
      page_q   <= 16'h0000;
      go_q     <= 1'b0;
      dvalid_q <= 1'b0;
      dword_q  <= 16'h0000;
      imask_q  <= 3'h0;
    end else if (ce_in) begin
      go_q     <= 1'b0;
      dvalid_q <= 1'b0;
      if (wr_w) begin
        unique case (idx_w)
          REG_CTRL: begin
            opc_q <= wb_dat_in[7:0];
            go_q  <= 1'b1;
          end
          REG_COUNT:    count_q <= wb_dat_in[15:0];
          REG_LOG:      log_q   <= wb_dat_in[7:0];
          REG_PAGE:     page_q  <= wb_dat_in[15:0];
          REG_DATA: begin
            dword_q  <= wb_dat_in[15:0];
            dvalid_q <= lnk.drq;
          end
          REG_IRQ_MASK: imask_q <= wb_dat_in[2:0];
          default: ;
        endcase
      end
    end
  end

  // sticky events, set wins over clear
  always_ff @(posedge clock_in) begin
    if (srst_in)
      ist_q <= 3'h0;
    else if (ce_in) begin
      if (wr_w && idx_w == REG_IRQ_STAT)
        ist_q <= (ist_q & ~wb_dat_in[2:0]) | ev_w;
      else
        ist_q <= ist_q | ev_w;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in)
      irq_out <= 1'b0;
    else if (ce_in)
      irq_out <= |(ist_q & imask_q & IRQ_ALL);
  end

  // wishbone answer one cycle after request
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else if (ce_in) begin
      wb_ack_out <= wb_cyc_in && wb_stb_in && !wb_ack_out;
      unique case (idx_w)
        REG_CTRL:     wb_dat_out <= {24'h00_0000, opc_q};
        REG_COUNT:    wb_dat_out <= {16'h0000, count_q};
        REG_LOG:      wb_dat_out <= {24'h00_0000, log_q};
        REG_PAGE:     wb_dat_out <= {16'h0000, page_q};
        REG_DATA:     wb_dat_out <= {31'h0000_0000, lnk.drq};
        REG_RESULT:   wb_dat_out <= {16'h0000, lnk.error_reg, lnk.status_reg};
        REG_IRQ_STAT: wb_dat_out <= {29'h0000_0000, ist_q};
        REG_IRQ_MASK: wb_dat_out <= {29'h0000_0000, imask_q};
        default:      wb_dat_out <= 32'h0000_0000;
      endcase
    end
  end

  assign lnk.cmd_valid    = go_q;
  assign lnk.cmd_opcode   = opc_q;
  assign lnk.count_cur    = count_q[7:0];
  assign lnk.count_prev   = count_q[15:8];
  assign lnk.log_addr     = log_q;
  assign lnk.page_cur     = page_q[7:0];
  assign lnk.page_prev    = page_q[15:8];
  assign lnk.data_valid   = dvalid_q;
  assign lnk.data_word    = dword_q;
  assign lnk.data_crc_err = 1'b0;
endmodule : lpw_host
`default_nettype wire

//--- lpw_if.sv
// command block link between host adapter and drive
`timescale 1ns/100ps
`default_nettype none
interface lpw_if;
  logic        cmd_valid;
  logic [7:0]  cmd_opcode;
  logic [7:0]  count_cur;
  logic [7:0]  count_prev;
  logic [7:0]  log_addr;
  logic [7:0]  page_cur;
  logic [7:0]  page_prev;
  logic        data_valid;
  logic [15:0] data_word;
  logic        data_crc_err;
  logic        drq;
  logic        intrq;
  logic        done;
  logic [7:0]  error_reg;
  logic [7:0]  status_reg;
  modport host (output cmd_valid, cmd_opcode, count_cur, count_prev, log_addr,
                page_cur, page_prev, data_valid, data_word, data_crc_err,
                input drq, intrq, done, error_reg, status_reg);
  modport dev  (input cmd_valid, cmd_opcode, count_cur, count_prev, log_addr,
                page_cur, page_prev, data_valid, data_word, data_crc_err,
                output drq, intrq, done, error_reg, status_reg);
endinterface : lpw_if
`default_nettype wire

//--- lpw_pkg.sv
// shared constants for the log page write link
package lpw_pkg;
  localparam logic [7:0]  OPC_PIO_WRITE  = 8'h3F;
  localparam logic [7:0]  OPC_DMA_WRITE  = 8'h57;
  localparam logic [9:0]  WORDS_PER_SEC  = 10'h100;
  localparam logic [15:0] SECTOR_BYTES   = 16'h0200;
  localparam logic [7:0]  LOG_COUNT      = 8'h04;
  localparam logic [7:0]  BLOCK_SECTORS  = 8'h01;
  // error register bit positions
  localparam int ERR_CRC           = 7;
  localparam int ERR_UNCORRECTABLE = 6;
  localparam int ERR_ID_NOT_FOUND  = 4;
  localparam int ERR_ABORTED       = 2;
  // status register bit positions
  localparam int ST_BSY       = 7;
  localparam int ST_RDY       = 6;
  localparam int ST_FAULT     = 5;
  localparam int ST_SEEK_DONE = 4;
  localparam int ST_DRQ       = 3;
  localparam int ST_CORRECTED = 2;
  localparam int ST_ERR       = 0;
  // host wishbone register indices (word address bits 4:2)
  localparam logic [2:0] REG_CTRL     = 3'h0;
  localparam logic [2:0] REG_COUNT    = 3'h1;
  localparam logic [2:0] REG_LOG      = 3'h2;
  localparam logic [2:0] REG_PAGE     = 3'h3;
  localparam logic [2:0] REG_DATA     = 3'h4;
  localparam logic [2:0] REG_RESULT   = 3'h5;
  localparam logic [2:0] REG_IRQ_STAT = 3'h6;
  localparam logic [2:0] REG_IRQ_MASK = 3'h7;
  // interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_BLK  = 1;
  localparam int IRQ_WREQ = 2;
  localparam logic [2:0] IRQ_ALL = 3'h7;
endpackage : lpw_pkg

//--- tb.sv
// self-checking bench for both link ends
`timescale 1ns/100ps
`default_nettype none
module tb;
  import lpw_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        ce = 1'b1;
  logic [3:0]  en = 4'h7;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack, irq, wv;
  logic [7:0]  wlog, wword, exp_log;
  logic [15:0] wpage, wdata, exp_page;
  int          failures = 0, n_compared = 0, cycles = 0;
  int          n_done = 0, n_intrq = 0, n_wr = 0, d0 = 0;
  logic [47:0] ab [7] = '{48'h3F04_0001_0000, 48'h3F02_0001_0000, 48'h5703_0001_0000,
    48'h3F01_0003_0000, 48'h3F00_0000_0000, 48'hA500_0001_0000, 48'h5700_0002_0002};
  lpw_if lnk();
  lpw_host u_lpw_host (.clock_in(clk), .srst_in(rst), .ce_in(ce), .lnk(lnk),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .irq_out(irq));
  lpw_dev u_lpw_dev (.clock_in(clk), .srst_in(rst), .ce_in(ce), .lnk(lnk),
    .log_pages_in(32'h0201_0203), .log_writable_in(4'hB), .log_enabled_in(en),
    .wr_valid_out(wv), .wr_log_out(wlog), .wr_page_out(wpage), .wr_word_out(wword),
    .wr_data_out(wdata));
  lpw_asserts u_lpw_asserts (.clock_in(clk), .srst_in(rst), .cmd_valid(lnk.cmd_valid),
    .cmd_opcode(lnk.cmd_opcode), .count_cur(lnk.count_cur), .count_prev(lnk.count_prev),
    .log_addr(lnk.log_addr), .data_valid(lnk.data_valid), .drq(lnk.drq),
    .intrq(lnk.intrq), .done(lnk.done), .error_reg(lnk.error_reg),
    .status_reg(lnk.status_reg));
  always #12.5 clk = ~clk;
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [2:0] idx, input logic [31:0] d,
                    output logic [31:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic send_cmd(input logic [47:0] c);
    logic [31:0] r;
    d0 = n_done;
    wb(1'b1, REG_COUNT, {16'h0000, c[31:16]}, r);
    wb(1'b1, REG_LOG, {24'h00_0000, c[39:32]}, r);
    wb(1'b1, REG_PAGE, {16'h0000, c[15:0]}, r);
    wb(1'b1, REG_CTRL, {24'h00_0000, c[47:40]}, r);
  endtask : send_cmd
  task automatic launch(input logic [47:0] c);
    send_cmd(c);
    while (n_done == d0) @(posedge clk);
  endtask : launch
  task automatic t_xfer(input logic [47:0] c, input int nint);
    logic [31:0] r;
    exp_log = c[39:32];
    exp_page = c[15:0];
    n_wr = 0;
    n_intrq = 0;
    send_cmd(c);
    do wb(1'b0, REG_DATA, 32'h0000_0000, r); while (r[0] !== 1'b1);
    for (int i = 0; i < 256 * int'(c[31:16]); i++) begin
      wb(1'b1, REG_DATA, 32'(i), r);
    end
    while (n_done == d0) @(posedge clk);
    repeat (2) @(posedge clk);
    wb(1'b0, REG_RESULT, 32'h0000_0000, r);
    chk("result", r, 32'h0000_0050);
    chk("words", n_wr, 256 * int'(c[31:16]));
    chk("intrq", n_intrq, nint);
  endtask : t_xfer
  task automatic t_abort();
    logic [31:0] r;
    foreach (ab[i]) begin
      n_wr = 0;
      launch(ab[i]);
      wb(1'b0, REG_RESULT, 32'h0000_0000, r);
      chk("abort", r, 32'h0000_0451);
      wb(1'b0, REG_DATA, 32'h0000_0000, r);
      chk("drq", {31'h0, r[0]} | n_wr, 32'h0000_0000);
    end
    en <= 4'h6;
    launch(48'h3F00_0001_0000);
    wb(1'b0, REG_RESULT, 32'h0000_0000, r);
    chk("disabled", r, 32'h0000_0451);
    en <= 4'h7;
  endtask : t_abort
  task automatic t_irq();
    logic [31:0] r;
    logic        a;
    wb(1'b1, REG_IRQ_STAT, {29'h0, IRQ_ALL}, r);
    wb(1'b0, REG_IRQ_STAT, 32'h0000_0000, r);
    chk("irq_clear", {r[2:0], irq}, 32'h0000_0000);
    wb(1'b1, REG_IRQ_MASK, 32'h0000_0000, r);
    launch(ab[5]);
    wb(1'b0, REG_IRQ_STAT, 32'h0000_0000, r);
    chk("irq_done", {31'h0, r[IRQ_DONE]}, 32'h0000_0001);
    a = irq;
    wb(1'b1, REG_IRQ_STAT, {29'h0, IRQ_ALL}, r);
    wb(1'b1, REG_IRQ_MASK, {29'h0, IRQ_ALL}, r);
    launch(ab[5]);
    wb(1'b0, REG_IRQ_STAT, 32'h0000_0000, r);
    chk("irq_mask", {31'h0, a ^ irq}, 32'h0000_0001);
  endtask : t_irq
  always @(posedge clk) begin
    cycles++;
    if (lnk.done === 1'b1) n_done++;
    if (lnk.intrq === 1'b1) n_intrq++;
    if (wv === 1'b1) begin
      chk("wr_log", {24'h0, wlog}, {24'h0, exp_log});
      chk("wr_page", {16'h0, wpage}, {16'h0, exp_page} + 32'(n_wr / 256));
      chk("wr_word", {24'h0, wword}, 32'(n_wr % 256));
      chk("wr_data", {16'h0, wdata}, 32'(n_wr));
      n_wr++;
    end
    if (cycles > 20000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_xfer(48'h3F00_0002_0001, 2);
    t_xfer(48'h5701_0001_0000, 1);
    t_abort();
    t_irq();
    end_sim();
  end
endmodule : tb
`default_nettype wire
